// ===== rtl/irq_standby_consts.svh
// Constants for the host interrupt and standby control block.
// Assumes a 10 MHz system clock on mclk.
`ifndef IRQ_STANDBY_CONSTS_SVH
`define IRQ_STANDBY_CONSTS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define MUTE_LEAD_NS 2000
// Least time rounds up
`define MUTE_LEAD_CYC ((`MUTE_LEAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------
// Interrupt source bit positions
// ----------------------------------------
`define SRC_KEY 0
`define SRC_RC 1
`define SRC_WAKE 2
`define SRC_ALARM 3
`define SRC_WDOG 4
`define SRC_OSC 5
`define SRC_GPIO 6
`define SRC_BATT 7
`define SRC_THERM 8
`define SRC_HOTKEY 9
`define NUM_SRC 10

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define KEY_W 16
`define GPIO_W 2
`define GUARD_W 16
`define HOTKEY_ADDRS 8
`define PEND_RST 10'h000
`define GUARD_RST 16'hffff

`endif

// ===== rtl/irq_standby_pkg.sv
// Types for the host interrupt and standby control block.
// Assumes the constants header is compiled alongside.
package irq_standby_pkg;
	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_MUTE_WAIT = 4'h2,
		ST_STANDBY = 4'h4,
		ST_WAKE = 4'h8
	} power_state_t;
endpackage

// ===== rtl/hotkey_match.sv
// Hotkey matcher: a small table of device addresses and command bytes.
// Assumes the table is loaded from the same clock domain.
`timescale 1ns/1ps
`include "irq_standby_consts.svh"

module hotkey_match (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic addr_wr,
	input wire logic [2:0] addr_idx,
	input wire logic [7:0] addr_data,
	input wire logic [7:0] cmd_data,
	input wire logic rc_valid,
	input wire logic [7:0] rc_addr,
	input wire logic [7:0] rc_cmd,
	output logic hit_q
);
	logic [7:0] addr_mem_q [`HOTKEY_ADDRS];
	logic [7:0] cmd_mem_q [`HOTKEY_ADDRS];
	logic [`HOTKEY_ADDRS-1:0] used_q;
	logic hit_d;

	// ----------------------------------------
	// Table storage
	// ----------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			used_q <= 8'h00;
			for (int i = 0; i < `HOTKEY_ADDRS; i++) begin
				addr_mem_q[i] <= 8'h00;
				cmd_mem_q[i] <= 8'h00;
			end
		end else if (addr_wr) begin
			used_q[addr_idx] <= 1'b1;
			addr_mem_q[addr_idx] <= addr_data;
			cmd_mem_q[addr_idx] <= cmd_data;
		end
	end

	// Compare incoming code against every stored pair
	always_comb begin
		hit_d = 1'b0;
		for (int i = 0; i < `HOTKEY_ADDRS; i++) begin
			if (used_q[i] && addr_mem_q[i] == rc_addr &&
				cmd_mem_q[i] == rc_cmd)
				hit_d = 1'b1;
		end
		hit_d = hit_d & rc_valid;
	end

	// Registered hit pulse
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			hit_q <= 1'b0;
		else
			hit_q <= hit_d;
	end
endmodule

// ===== rtl/host_interrupt_standby_control.sv
// Host interrupt gathering and standby power handshake.
// Assumes event strobes on mclk, pins synchronised here, pull-up outside.
// Contract
// - Interrupt to host is signalled by pulling the line low, always.
// - Front-panel or remote key press, toggle change included, interrupts.
// - Rising edge on the wake pin interrupts.
// - Alarm, watchdog expiry or oscillator failure interrupts.
// - Line stays low until the interrupt buffer has been read.
// - Buffer names the exact source, down to the key.
// - Line is open drain, only pulls low; pull-up is outside.
// - New key or GPIO data during a read updates data; it interrupts again only if its bit was not in the snapshot.
// - Stored hotkeys, up to eight addresses, wake the system.
// - Ready falling drives standby request high.
// - Ready low after boot or wake asserts standby at guard zero.
// - Ready falling mutes at once, standby at least 2 us later.
// - Ready high asserts standby only if guard enabled and expired.
// - Mute before power off, unmute right after ready rises on wake.
`timescale 1ns/1ps
`include "irq_standby_consts.svh"

module host_interrupt_standby_control
	import irq_standby_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic key_event,
	input wire logic [`KEY_W-1:0] key_code,
	input wire logic rc_event,
	input wire logic rc_toggle,
	input wire logic [7:0] rc_addr,
	input wire logic [7:0] rc_cmd,
	input wire logic wake_pin,
	input wire logic alarm_event,
	input wire logic wdog_event,
	input wire logic osc_fail_event,
	input wire logic [`GPIO_W-1:0] gpio_in,
	input wire logic batt_low_event,
	input wire logic therm_event,
	input wire logic hotkey_wr,
	input wire logic [2:0] hotkey_idx,
	input wire logic [7:0] hotkey_addr,
	input wire logic [7:0] hotkey_cmd,
	input wire logic rd_start,
	input wire logic rd_done,
	output logic [`NUM_SRC-1:0] irq_buffer,
	output logic [`KEY_W-1:0] key_data,
	output logic [`GPIO_W-1:0] gpio_data,
	input wire logic ready_pin,
	input wire logic guard_en,
	input wire logic guard_clear,
	input wire logic [`GUARD_W-1:0] guard_load,
	output logic irq_n_out,
	output logic irq_n_oe,
	output logic standby_request,
	output logic mute,
	output logic wake_request
);
	logic [1:0] wake_sync_q;
	logic [1:0] ready_sync_q;
	logic [`GPIO_W-1:0] gpio_s1_q;
	logic [`GPIO_W-1:0] gpio_s2_q;
	logic [`GPIO_W-1:0] gpio_prev_q;
	logic wake_prev_q;
	logic ready_prev_q;
	logic rc_toggle_q;
	logic [`NUM_SRC-1:0] pend_q;
	logic [`NUM_SRC-1:0] snap_q;
	logic reading_q;
	logic [`NUM_SRC-1:0] ev;
	logic [`KEY_W-1:0] key_q;
	logic [`GPIO_W-1:0] gpio_q;
	logic hotkey_hit;
	logic ready_s;
	logic ready_fall;
	logic ready_rise;
	logic [`GUARD_W-1:0] guard_q;
	logic guard_zero;
	logic [5:0] lead_q;
	power_state_t state_q;
	logic standby_request_q;
	logic mute_q;
	logic boot_q;
	logic wake_ev;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wake_sync_q <= 2'h0;
			ready_sync_q <= 2'h0;
			gpio_s1_q <= 2'h0;
			gpio_s2_q <= 2'h0;
		end else begin
			wake_sync_q <= {wake_sync_q[0], wake_pin};
			ready_sync_q <= {ready_sync_q[0], ready_pin};
			gpio_s1_q <= gpio_in;
			gpio_s2_q <= gpio_s1_q;
		end
	end

	assign ready_s = ready_sync_q[1];

	// Edge history
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wake_prev_q <= 1'b0;
			ready_prev_q <= 1'b0;
			gpio_prev_q <= 2'h0;
			rc_toggle_q <= 1'b0;
		end else begin
			wake_prev_q <= wake_sync_q[1];
			ready_prev_q <= ready_s;
			gpio_prev_q <= gpio_s2_q;
			if (rc_event)
				rc_toggle_q <= rc_toggle;
		end
	end

	assign ready_fall = ready_prev_q & ~ready_s;
	assign ready_rise = ~ready_prev_q & ready_s;

	hotkey_match u_hotkey (
		.mclk(mclk),
		.arst_n(arst_n),
		.addr_wr(hotkey_wr),
		.addr_idx(hotkey_idx),
		.addr_data(hotkey_addr),
		.cmd_data(hotkey_cmd),
		.rc_valid(rc_event),
		.rc_addr(rc_addr),
		.rc_cmd(rc_cmd),
		.hit_q(hotkey_hit)
	);

	// ----------------------------------------
	// Event gathering
	// ----------------------------------------
	always_comb begin
		ev = `PEND_RST;
		ev[`SRC_KEY] = key_event;
		ev[`SRC_RC] = rc_event | (rc_event & (rc_toggle ^ rc_toggle_q));
		ev[`SRC_WAKE] = wake_sync_q[1] & ~wake_prev_q;
		ev[`SRC_ALARM] = alarm_event;
		ev[`SRC_WDOG] = wdog_event;
		ev[`SRC_OSC] = osc_fail_event;
		ev[`SRC_GPIO] = |(gpio_s2_q ^ gpio_prev_q);
		ev[`SRC_BATT] = batt_low_event;
		ev[`SRC_THERM] = therm_event;
		ev[`SRC_HOTKEY] = hotkey_hit;
	end

	// Read window: snapshot is what the host sees
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			reading_q <= 1'b0;
			snap_q <= `PEND_RST;
		end else if (rd_start && !reading_q) begin
			reading_q <= 1'b1;
			snap_q <= pend_q;
		end else if (rd_done) begin
			reading_q <= 1'b0;
		end
	end

	// Pending bits: set wins over clear of reported bits
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			pend_q <= `PEND_RST;
		else if (reading_q && rd_done)
			pend_q <= (pend_q & ~snap_q) | ev;
		else
			pend_q <= pend_q | ev;
	end

	// Key and GPIO data always follow new input
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			key_q <= 16'h0000;
			gpio_q <= 2'h0;
		end else begin
			if (key_event)
				key_q <= key_code;
			gpio_q <= gpio_s2_q;
		end
	end

	assign irq_buffer = snap_q;
	assign key_data = key_q;
	assign gpio_data = gpio_q;
	// Line held low while any bit pends; released for the whole read window
	assign irq_n_out = 1'b0;
	assign irq_n_oe = reading_q ? 1'b0 : (|pend_q);
	// Plain remote codes only pend; stored hotkeys and other sources wake
	assign wake_ev = ev[`SRC_KEY] | (|ev[`NUM_SRC-1:`SRC_RC+1]);
	assign wake_request = (state_q == ST_STANDBY) & wake_ev;

	// ----------------------------------------
	// Guard timer
	// ----------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			guard_q <= `GUARD_RST;
		else if (guard_clear)
			guard_q <= guard_load;
		else if ((guard_en || boot_q) && guard_q != 16'h0000)
			guard_q <= guard_q - 16'h0001;
	end

	assign guard_zero = (guard_q == 16'h0000);

	// ----------------------------------------
	// Standby and mute sequencing
	// ----------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_WAKE;
			standby_request_q <= 1'b0;
			mute_q <= 1'b1;
			lead_q <= 6'h00;
			boot_q <= 1'b1;
		end else begin
			case (state_q)
			ST_RUN: begin
				if (ready_fall || (!ready_s && guard_zero) ||
					(ready_s && guard_en && guard_zero)) begin
					mute_q <= 1'b1;
					lead_q <= 6'h00;
					state_q <= ST_MUTE_WAIT;
				end
			end
			ST_MUTE_WAIT: begin
				if (lead_q >= 6'(`MUTE_LEAD_CYC - 1)) begin
					standby_request_q <= 1'b1;
					state_q <= ST_STANDBY;
				end else
					lead_q <= lead_q + 6'h01;
			end
			ST_STANDBY: begin
				if (wake_ev) begin
					standby_request_q <= 1'b0;
					boot_q <= 1'b1;
					state_q <= ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (ready_rise || ready_s) begin
					mute_q <= 1'b0;
					boot_q <= 1'b0;
					state_q <= ST_RUN;
				end else if (guard_zero) begin
					mute_q <= 1'b1;
					lead_q <= 6'h00;
					state_q <= ST_MUTE_WAIT;
				end
			end
			default: state_q <= ST_WAKE;
			endcase
		end
	end

	assign standby_request = standby_request_q;
	assign mute = mute_q;
endmodule

// ===== sim/host_model.sv
// Host processor model: ready output, irq line with pull-up, buffer read.
// Assumes design inputs change at the falling edge of mclk.
`timescale 1ns/1ps
module host_model #(
	parameter int DLY = 4
) (
	input wire logic mclk,
	input wire logic irq_n_out,
	input wire logic irq_n_oe,
	input wire logic [9:0] irq_buffer,
	input wire logic ready_lvl,
	input wire logic auto,
	output logic ready_pin,
	output logic guard_en,
	output logic rd_start,
	output logic rd_done,
	output logic [9:0] last,
	output int n_rd
);
	logic line;
	// Pull-up wins when nothing pulls low
	assign line = irq_n_oe ? irq_n_out : 1'b1;
	assign ready_pin = ready_lvl;
	assign guard_en = 1'b0;
	// Read the buffer some cycles after the line goes low
	initial begin
		rd_start = 1'b0;
		rd_done = 1'b0;
		last = 10'h000;
		n_rd = 0;
		forever begin
			@(negedge mclk);
			if (auto && line === 1'b0) begin
				repeat (DLY) @(negedge mclk);
				rd_start = 1'b1;
				@(negedge mclk);
				rd_start = 1'b0;
				@(negedge mclk);
				last = irq_buffer;
				rd_done = 1'b1;
				@(negedge mclk);
				rd_done = 1'b0;
				n_rd++;
			end
		end
	end
endmodule

// ===== sim/host_interrupt_standby_control_checker.sv
// Checker for the interrupt line and the standby handshake.
// Assumes it is bound into the top module and sees only its ports.
`timescale 1ns/1ps
module host_interrupt_standby_control_checker (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic key_event,
	input wire logic alarm_event,
	input wire logic rd_start,
	input wire logic rd_done,
	input wire logic ready_pin,
	input wire logic irq_n_out,
	input wire logic irq_n_oe,
	input wire logic standby_request,
	input wire logic mute
);
	logic rd_q;
	logic [7:0] mute_cnt_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// Host read window
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rd_q <= 1'b0;
		end else if (rd_start) begin
			rd_q <= 1'b1;
		end else if (rd_done) begin
			rd_q <= 1'b0;
		end
	end
	// Cycles that mute has stood high, saturating
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mute_cnt_q <= 8'h00;
		end else if (!mute) begin
			mute_cnt_q <= 8'h00;
		end else if (mute_cnt_q != 8'hff) begin
			mute_cnt_q <= mute_cnt_q + 8'h01;
		end
	end
	a_line_only_low: assert property (irq_n_out == 1'b0)
		else $error("irq line driven high");
	a_key_raises_irq: assert property (key_event && !rd_q && !rd_start
		|=> irq_n_oe) else $error("key gave no irq");
	a_alarm_raises_irq: assert property (alarm_event && !rd_q
		&& !rd_start |=> irq_n_oe) else $error("alarm gave no irq");
	a_irq_holds_low: assert property (irq_n_oe && !rd_start |=> irq_n_oe)
		else $error("irq released without read");
	a_read_stays_quiet: assert property (rd_q |-> !irq_n_oe)
		else $error("irq during read");
	a_fall_mutes: assert property ($fell(ready_pin) |-> ##[1:5] mute)
		else $error("mute late after ready fall");
	a_standby_lead: assert property ($rose(standby_request)
		|-> mute_cnt_q >= 8'h14) else $error("standby too soon");
	a_rise_unmutes: assert property ($rose(ready_pin) |-> ##[1:5] !mute)
		else $error("mute late after ready rise");
	a_standby_muted: assert property (standby_request |-> mute)
		else $error("standby without mute");
endmodule
bind host_interrupt_standby_control host_interrupt_standby_control_checker
	chk_i (.mclk, .arst_n, .key_event, .alarm_event, .rd_start, .rd_done,
	.ready_pin, .irq_n_out, .irq_n_oe, .standby_request, .mute);

// ===== sim/host_interrupt_standby_control_tb.sv
// Testbench: event sources, read window, standby and wake handshake.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module host_interrupt_standby_control_tb;
	logic mclk = 0, arst_n = 0, key_event = 0, rc_event = 0, rc_toggle = 0;
	logic wake_pin = 0, alarm_event = 0, wdog_event = 0, osc_fail_event = 0;
	logic batt_low_event = 0, therm_event = 0, hotkey_wr = 0, guard_clear = 0;
	logic ready_lvl = 1, auto = 1, rd_start, rd_done, ready_pin, guard_en;
	logic [15:0] key_code = 16'h0000, guard_load = 16'h0000, key_data;
	logic [7:0] rc_addr = 8'h00, rc_cmd = 8'h00;
	logic [7:0] hotkey_addr = 8'h00, hotkey_cmd = 8'h00;
	logic [2:0] hotkey_idx = 3'h0;
	logic [1:0] gpio_in = 2'h0, gpio_data;
	logic [9:0] irq_buffer, last;
	logic irq_n_out, irq_n_oe, standby_request, mute, wake_request;
	int n_fail = 0, comparisons = 0, n_rd;
	host_interrupt_standby_control dut (
		.mclk(mclk), .arst_n(arst_n), .key_event(key_event),
		.key_code(key_code), .rc_event(rc_event), .rc_toggle(rc_toggle),
		.rc_addr(rc_addr), .rc_cmd(rc_cmd), .wake_pin(wake_pin),
		.alarm_event(alarm_event), .wdog_event(wdog_event),
		.osc_fail_event(osc_fail_event), .gpio_in(gpio_in),
		.batt_low_event(batt_low_event), .therm_event(therm_event),
		.hotkey_wr(hotkey_wr), .hotkey_idx(hotkey_idx),
		.hotkey_addr(hotkey_addr), .hotkey_cmd(hotkey_cmd),
		.rd_start(rd_start), .rd_done(rd_done), .irq_buffer(irq_buffer),
		.key_data(key_data), .gpio_data(gpio_data), .ready_pin(ready_pin),
		.guard_en(guard_en), .guard_clear(guard_clear),
		.guard_load(guard_load), .irq_n_out(irq_n_out),
		.irq_n_oe(irq_n_oe), .standby_request(standby_request),
		.mute(mute), .wake_request(wake_request)
	);
	host_model host (
		.mclk(mclk), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
		.irq_buffer(irq_buffer), .ready_lvl(ready_lvl), .auto(auto),
		.ready_pin(ready_pin), .guard_en(guard_en), .rd_start(rd_start),
		.rd_done(rd_done), .last(last), .n_rd(n_rd)
	);
	always #50 mclk = ~mclk;
	task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wait_rd(int n);
		int k;
		k = 0;
		while (n_rd < n && k < 200) begin
			@(negedge mclk);
			k++;
		end
		if (n_rd < n) begin
			n_fail++;
			$display("[FAIL] n_rd expected %0d seen %0d", n, n_rd);
			test_done();
		end
	endtask
	// One event from source i; strobes drop after one cycle, wake pin and GPIO stay set
	task automatic fire(int i);
		case (i)
			0: key_event = 1'b1;
			1: rc_event = 1'b1;
			2: wake_pin = 1'b1;
			3: alarm_event = 1'b1;
			4: wdog_event = 1'b1;
			5: osc_fail_event = 1'b1;
			6: gpio_in = 2'h1;
			7: batt_low_event = 1'b1;
			default: therm_event = 1'b1;
		endcase
		@(negedge mclk);
		key_event = 1'b0;
		rc_event = 1'b0;
		{alarm_event, wdog_event, osc_fail_event} = 3'h0;
		{batt_low_event, therm_event} = 2'h0;
	endtask
	task automatic t_sources();
		int n;
		for (int i = 0; i < 9; i++) begin
			n = n_rd;
			key_code = 16'h0100 + 16'(i);
			fire(i);
			wait_rd(n + 1);
			chk("irq_buffer", 16'(10'h001 << i), 16'(last));
		end
		chk("key_data", 16'h0100, key_data);
		chk("gpio_data", 16'h0001, 16'(gpio_data));
		$display("test sources done");
	endtask
	task automatic t_read_busy();
		int n;
		n = n_rd;
		key_code = 16'h00a1;
		fire(0);
		@(posedge rd_start);
		@(negedge mclk);
		key_code = 16'h00b2;
		fire(0);
		chk("irq_n_oe", 16'h0000, 16'(irq_n_oe));
		wait_rd(n + 1);
		repeat (10) @(negedge mclk);
		chk("n_rd", 16'(n + 1), 16'(n_rd));
		chk("irq_n_oe", 16'h0000, 16'(irq_n_oe));
		chk("key_data", 16'h00b2, key_data);
		chk("irq_buffer", 16'h0001, 16'(last));
		$display("test read busy done");
	endtask
	task automatic t_standby();
		int k;
		{hotkey_idx, hotkey_addr, hotkey_cmd} = {3'h2, 8'h35, 8'h4c};
		hotkey_wr = 1'b1;
		@(negedge mclk);
		hotkey_wr = 1'b0;
		auto = 1'b0;
		ready_lvl = 1'b0;
		k = 0;
		while (standby_request !== 1'b1 && k < 60) begin
			@(negedge mclk);
			k++;
		end
		chk("standby_request", 16'h0001, 16'(standby_request));
		chk("mute", 16'h0001, 16'(mute));
		{rc_addr, rc_cmd} = {8'h35, 8'h4d};
		fire(1);
		repeat (3) @(negedge mclk);
		chk("standby_request", 16'h0001, 16'(standby_request));
		{rc_addr, rc_cmd} = {8'h35, 8'h4c};
		fire(1);
		chk("wake_request", 16'h0001, 16'(wake_request));
		auto = 1'b1;
		wait_rd(n_rd + 1);
		chk("irq_buffer", 16'h0202, 16'(last));
		ready_lvl = 1'b1;
		repeat (5) @(negedge mclk);
		chk("mute", 16'h0000, 16'(mute));
		$display("test standby done");
	endtask
	// Guard loaded in run, then wake with ready held low
	task automatic t_guard();
		guard_load = 16'h0008;
		guard_clear = 1'b1;
		@(negedge mclk);
		guard_clear = 1'b0;
		auto = 1'b0;
		ready_lvl = 1'b0;
		repeat (30) @(negedge mclk);
		chk("standby_request", 16'h0001, 16'(standby_request));
		fire(0);
		chk("standby_request", 16'h0000, 16'(standby_request));
		repeat (24) @(negedge mclk);
		chk("standby_request", 16'h0000, 16'(standby_request));
		repeat (16) @(negedge mclk);
		chk("standby_request", 16'h0001, 16'(standby_request));
		chk("mute", 16'h0001, 16'(mute));
		$display("test guard done");
	endtask
	task automatic test_done();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Watchdog against a hang
	initial begin
		#500000;
		n_fail++;
		test_done();
	end
	initial begin
		repeat (16) @(negedge mclk);
		arst_n = 1'b1;
		repeat (6) @(negedge mclk);
		chk("mute", 16'h0000, 16'(mute));
		t_sources();
		t_read_busy();
		t_standby();
		t_guard();
		test_done();
	end
endmodule
